// ### core/bus_hold_pkg.sv
// Constants for the external bus hold handshake
package bus_hold_pkg;
	// Memory interface clock periods, counted in clk cycles (E = one clk period)
	localparam int FLOAT_MIN_E = 2;
	localparam int GRANT_MAX_E = 2;
	localparam int RESUME_MIN_E = 2;
	localparam int RESUME_MAX_E = 7;
	localparam int CLK_PERIOD_NS = 10;
	localparam int FLOAT_MIN_CYC = (FLOAT_MIN_E * CLK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RESUME_MIN_CYC = (RESUME_MIN_E * CLK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RESUME_MAX_CYC = (RESUME_MAX_E * CLK_PERIOD_NS) / CLK_PERIOD_NS;
	localparam int CNT_W = 3;
	localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;
	localparam logic [CNT_W-1:0] CNT_ONE = 3'h1;
	// Width of the floated bus group
	localparam int CHIP_EN_W = 4;
	localparam int BYTE_EN_W = 4;
	localparam int DATA_W = 32;
	localparam int ADDR_HI = 22;
	localparam int ADDR_LO = 3;
	localparam int STROBE_W = 3;
	localparam int GROUP_W = CHIP_EN_W + BYTE_EN_W + DATA_W + (ADDR_HI - ADDR_LO + 1) + STROBE_W + 3;
	localparam int CLK_OUT_N = 2;
	typedef enum logic [4:0] {
		ST_DRIVE = 5'h01,
		ST_DRAIN = 5'h02,
		ST_FLOAT = 5'h04,
		ST_HELD = 5'h08,
		ST_RESUME = 5'h10
	} hold_state_t;
endpackage

// ### core/hold_delay_counter.sv
`timescale 1ns/1ps
// Loadable down counter for the hold handshake delays
module hold_delay_counter #(
	parameter int W = 3
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Control
	input wire logic load,
	input wire logic [W-1:0] load_value,
	// Status
	output logic done
);
	logic [W-1:0] count_reg;
	logic [W-1:0] count_next;

	always_comb begin
		count_next = count_reg;
		if (load) begin
			count_next = load_value;
		end else if (count_reg != '0) begin
			count_next = count_reg - 1'b1;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			count_reg <= '0;
		end else begin
			count_reg <= count_next;
		end
	end

	assign done = (count_reg == '0) && !load;
endmodule

// ### core/external_bus_hold_handshake.sv
`timescale 1ns/1ps
// Hold request and grant handshake that floats the external memory bus
// Operation
// - Hold request low floats memory bus no sooner than two periods later.
// - Grant goes low zero to two periods after bus floats.
// - Request high resumes bus drive two to seven periods later.
// - Grant returns high zero to two periods after bus drives.
// - Pending transactions finish first; idle bus gives minimum delay.
// - Refusal bit set withholds grant and keeps driving the bus.
// - Clock outputs keep toggling or float per float-select bit.
// - Floating clock outputs follow the same float and resume timing.
// - Floated group: enables, data, address, strobes, clock enable, transfer.
module external_bus_hold_handshake #(
	parameter int NUM_CLK_OUT = bus_hold_pkg::CLK_OUT_N
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Hold handshake pins
	input wire logic hold_request_n,
	output logic bus_hold_grant_n,
	// Controls from the memory global control
	input wire logic hold_refusal_bit,
	input wire logic [NUM_CLK_OUT-1:0] clock_out_float_select,
	// Memory controller activity
	input wire logic transaction_pending,
	output logic hold_active,
	// Memory clock outputs and pin output enables, enables high while driven
	output logic bus_group_oe,
	output logic [NUM_CLK_OUT-1:0] memory_clock_output,
	output logic [NUM_CLK_OUT-1:0] memory_clock_output_oe
);
	bus_hold_pkg::hold_state_t state_reg;
	bus_hold_pkg::hold_state_t state_next;
	logic bus_oe_reg;
	logic bus_oe_next;
	logic grant_n_reg;
	logic grant_n_next;
	logic [NUM_CLK_OUT-1:0] clk_oe_reg;
	logic [NUM_CLK_OUT-1:0] clk_oe_next;
	logic [NUM_CLK_OUT-1:0] clk_out_reg;
	logic [NUM_CLK_OUT-1:0] clk_out_next;
	logic hold_active_reg;
	logic hold_active_next;
	logic cnt_load;
	logic [bus_hold_pkg::CNT_W-1:0] cnt_value;
	logic cnt_done;

	hold_delay_counter #(
		.W(bus_hold_pkg::CNT_W)
	) delay_counter (
		.clk(clk),
		.reset_n(reset_n),
		.load(cnt_load),
		.load_value(cnt_value),
		.done(cnt_done)
	);

	always_comb begin
		state_next = state_reg;
		bus_oe_next = bus_oe_reg;
		grant_n_next = grant_n_reg;
		clk_oe_next = clk_oe_reg;
		cnt_load = 1'b0;
		cnt_value = bus_hold_pkg::CNT_ZERO;
		unique case (state_reg)
			bus_hold_pkg::ST_DRIVE: begin
				if (!hold_request_n && !hold_refusal_bit) begin
					state_next = bus_hold_pkg::ST_DRAIN;
					cnt_load = 1'b1;
					cnt_value = bus_hold_pkg::CNT_W'(bus_hold_pkg::FLOAT_MIN_CYC - 1);
				end
			end
			bus_hold_pkg::ST_DRAIN: begin
				if (hold_request_n) begin
					state_next = bus_hold_pkg::ST_DRIVE;
				end else if (cnt_done && !transaction_pending && !hold_refusal_bit) begin
					state_next = bus_hold_pkg::ST_FLOAT;
					bus_oe_next = 1'b0;
					clk_oe_next = ~clock_out_float_select;
				end
			end
			bus_hold_pkg::ST_FLOAT: begin
				grant_n_next = 1'b0;
				state_next = bus_hold_pkg::ST_HELD;
			end
			bus_hold_pkg::ST_HELD: begin
				if (hold_request_n) begin
					state_next = bus_hold_pkg::ST_RESUME;
					cnt_load = 1'b1;
					cnt_value = bus_hold_pkg::CNT_W'(bus_hold_pkg::RESUME_MIN_CYC - 1);
				end
			end
			bus_hold_pkg::ST_RESUME: begin
				if (cnt_done) begin
					state_next = bus_hold_pkg::ST_DRIVE;
					bus_oe_next = 1'b1;
					clk_oe_next = '1;
					grant_n_next = 1'b1;
				end
			end
		endcase
		// hold flag tracks the floated group
		hold_active_next = ~bus_oe_next;
	end

	// Clock outputs toggle at half the core rate
	always_comb begin
		clk_out_next = ~clk_out_reg;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= bus_hold_pkg::ST_DRIVE;
			bus_oe_reg <= 1'b1;
			grant_n_reg <= 1'b1;
			clk_oe_reg <= '1;
			clk_out_reg <= '0;
			hold_active_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			bus_oe_reg <= bus_oe_next;
			grant_n_reg <= grant_n_next;
			clk_oe_reg <= clk_oe_next;
			clk_out_reg <= clk_out_next;
			hold_active_reg <= hold_active_next;
		end
	end

	assign bus_hold_grant_n = grant_n_reg;
	assign bus_group_oe = bus_oe_reg;
	assign memory_clock_output = clk_out_reg;
	assign memory_clock_output_oe = clk_oe_reg;
	assign hold_active = hold_active_reg;
endmodule

// ### sim/external_bus_hold_handshake_asserts.sv
// Checker for the bus hold handshake
`timescale 1ns/1ps
module external_bus_hold_handshake_asserts #(parameter int NUM_CLK_OUT = 2) (
	input wire logic clk, reset_n, hold_request_n, bus_hold_grant_n, hold_refusal_bit, transaction_pending,
	input wire logic [NUM_CLK_OUT-1:0] clock_out_float_select,
	input wire logic hold_active, bus_group_oe,
	input wire logic [NUM_CLK_OUT-1:0] memory_clock_output, memory_clock_output_oe
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	sequence s_float;
		$fell(bus_group_oe);
	endsequence
	chk_float_min: assert property (s_float |-> !$past(hold_request_n) && !$past(hold_request_n, 2))
		else $error("early float");
	chk_grant_win: assert property (s_float |-> ##[0:2] !bus_hold_grant_n)
		else $error("late grant");
	chk_resume_win: assert property ($rose(hold_request_n) && !bus_hold_grant_n |->
		!bus_group_oe [*2] ##[1:6] bus_group_oe)
		else $error("resume");
	chk_grant_high: assert property ($rose(bus_group_oe) |-> ##[0:2] bus_hold_grant_n)
		else $error("grant high");
	chk_drain_wait: assert property (transaction_pending && bus_group_oe |=> bus_group_oe)
		else $error("drain");
	chk_clk_sel: assert property (memory_clock_output_oe ==
		(bus_group_oe ? {NUM_CLK_OUT{1'b1}} : ~clock_out_float_select))
		else $error("clock oe");
	chk_clk_toggle: assert property ($past(reset_n) |-> memory_clock_output == ~$past(memory_clock_output))
		else $error("toggle");
	chk_group_one: assert property (hold_active == !bus_group_oe)
		else $error("group");
	chk_refuse_hold: assert property (hold_refusal_bit && bus_group_oe |=> bus_group_oe && bus_hold_grant_n)
		else $error("refusal");
endmodule

// ### sim/bus_master_model.sv
// Outside master that requests and uses the memory bus
`timescale 1ns/1ps
module bus_master_model (
	input wire logic clk, reset_n, want, abort_req, bus_hold_grant_n,
	output logic hold_request_n, master_drive
);
	logic granted_reg;
	always @(negedge clk or negedge reset_n) begin
		if (!reset_n) begin
			hold_request_n <= 1'b1;
			master_drive <= 1'b0;
			granted_reg <= 1'b0;
		end else begin
			granted_reg <= !bus_hold_grant_n;
			master_drive <= want && !bus_hold_grant_n;
			if (want)
				hold_request_n <= 1'b0;
			else if (!master_drive && (granted_reg || abort_req))
				hold_request_n <= 1'b1;
		end
	end
endmodule

// ### sim/tb_external_bus_hold_handshake.sv
// Bench for the bus hold handshake
`timescale 1ns/1ps
module tb_external_bus_hold_handshake;
	logic clk = 0, reset_n = 0, want = 0, abort_req = 0, hold_refusal_bit = 0, transaction_pending = 0;
	logic [1:0] clock_out_float_select = 2'h0;
	logic hold_request_n, bus_hold_grant_n, hold_active, bus_group_oe, master_drive;
	logic [1:0] memory_clock_output, memory_clock_output_oe;
	int n_fail = 0, check_count = 0, lat, p;
	always #5 clk = ~clk;
	external_bus_hold_handshake u_dut (.clk, .reset_n, .hold_request_n, .bus_hold_grant_n, .hold_refusal_bit,
		.clock_out_float_select, .transaction_pending, .hold_active, .bus_group_oe, .memory_clock_output,
		.memory_clock_output_oe);
	bus_master_model u_master (.clk, .reset_n, .want, .abort_req, .bus_hold_grant_n, .hold_request_n, .master_drive);
	task automatic cmp_lat(input int got, input int lo, input int hi);
		check_count++;
		if (got < lo || got > hi) begin
			n_fail++;
			$display("Error %0t latency %0d", $time, got);
		end
	endtask
	task automatic cmp_val(input logic [3:0] got, input logic [3:0] exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("Error %0t value %h", $time, got);
		end
	endtask
	task automatic wrap_up;
		if (n_fail == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		#50000;
		n_fail++;
		wrap_up();
	end
	initial begin
		void'($urandom(32'hCC94EB61));
		repeat (8) @(negedge clk);
		reset_n = 1;
		for (int i = 0; i < 12; i++) begin
			p = $urandom_range(3, 0) * (i % 2);
			@(negedge clk);
			clock_out_float_select <= 2'($urandom);
			want <= 1'b1;
			transaction_pending <= p > 0;
			lat = 0;
			while (bus_group_oe !== 1'b0 && lat < 20) begin
				@(negedge clk);
				lat++;
				if (lat > p)
					transaction_pending <= 1'b0;
			end
			cmp_lat(lat, p < 2 ? 4 : p + 2, p + 5);
			@(negedge clk);
			cmp_val({bus_hold_grant_n, hold_active, memory_clock_output_oe}, {2'b01, ~clock_out_float_select});
			want <= 1'b0;
			lat = 0;
			while (bus_group_oe !== 1'b1 && lat < 20) begin
				@(negedge clk);
				lat++;
			end
			cmp_lat(lat, 5, 9);
			repeat (2) @(negedge clk);
			cmp_val({bus_hold_grant_n, hold_active, memory_clock_output_oe}, 4'hB);
		end
		hold_refusal_bit <= 1'b1;
		want <= 1'b1;
		repeat (20) @(negedge clk);
		cmp_val({bus_hold_grant_n, hold_active, master_drive, bus_group_oe}, 4'h9);
		want <= 1'b0;
		abort_req <= 1'b1;
		repeat (3) @(negedge clk);
		wrap_up();
	end
endmodule
bind external_bus_hold_handshake external_bus_hold_handshake_asserts #(.NUM_CLK_OUT(NUM_CLK_OUT)) u_chk (.*);
